// >>> logic/drive_status_map.vh
// Purpose: Register offsets, field positions, reset values and timing counts for drive status logic.
// Assumes: 32-bit APB, one aligned word per register.
// Notes: Definitions only.
`ifndef DRIVE_STATUS_MAP_VH
`define DRIVE_STATUS_MAP_VH
// Register byte offsets.
`define OFS_CTRL 12'h000
`define OFS_START_FREQ 12'h004
`define OFS_SET_FREQ 12'h008
`define OFS_ACC_TH1 12'h00C
`define OFS_DEC_TH1 12'h010
`define OFS_ACC_TH2 12'h014
`define OFS_DEC_TH2 12'h018
`define OFS_MAX_FREQ 12'h01C
`define OFS_OUT_SEL 12'h020
`define OFS_COUNT_MON 12'h024
`define OFS_STATUS 12'h028
`define OFS_IRQ_STAT 12'h02C
`define OFS_IRQ_EN 12'h030
`define OFS_IRQ_CLR 12'h034
// Control fields.
`define CTRL_RUN_BIT 0
`define CTRL_CLR_BIT 1
// Selector codes. Reset: terminal 0 arrival one, 1 run, 2 to 4 off, relay alarm.
`define SEL_W 3
`define FUNC_RUN 3'h0
`define FUNC_FA1 3'h1
`define FUNC_FA2 3'h2
`define FUNC_FA3 3'h3
`define FUNC_FA4 3'h4
`define FUNC_FA5 3'h5
`define FUNC_ALARM 3'h6
`define FUNC_OFF 3'h7
`define OUT_SEL_RST 21'h037FC1
// Interrupt bit positions.
`define IRQ_CNT_BIT 0
`define IRQ_RUN_BIT 1
`define IRQ_W 7
// Count input rate limit (Hz) and clock rate.
`define CLK_HZ 50000000
`define PULSE_MAX_HZ 100
`endif

// >>> logic/arrival_comp.v
// Purpose: One frequency arrival comparator with 1% on and 2% off hysteresis.
// Assumes: Frequencies are unsigned of equal width; band values precomputed.
// Notes: Mode 0 is level-above, mode 1 is at-threshold window.
`timescale 1ns/1ps
`default_nettype none
module arrival_comp #(
   parameter W = 16
) (
   // Clock and reset.
   input wire clk_i,
   input wire rst_i,
   // Comparison inputs.
   input wire [W-1:0] freq_i,
   input wire [W-1:0] thr_i,
   input wire [W-1:0] on_band_i,
   input wire [W-1:0] off_band_i,
   input wire window_i,
   input wire enable_i,
   // Result.
   output reg on_o
);
   // Extended arithmetic avoids wrap near zero and full scale.
   wire [W:0] f = {1'b0, freq_i};
   wire [W:0] t = {1'b0, thr_i};
   wire [W:0] on_lo = (t > {1'b0, on_band_i}) ? t - {1'b0, on_band_i} : {(W+1){1'b0}};
   wire [W:0] off_lo = (t > {1'b0, off_band_i}) ? t - {1'b0, off_band_i} : {(W+1){1'b0}};
   wire [W:0] on_hi = t + {1'b0, on_band_i};
   wire [W:0] off_hi = t + {1'b0, off_band_i};
   // Turn-on test anticipates by the on band; turn-off waits for the off band.
   wire hit_on = window_i ? (f >= on_lo && f <= on_hi) : (f >= on_lo);
   wire keep = window_i ? (f >= off_lo && f <= off_hi) : (f >= off_lo);

   // Hysteresis flop: once on, it stays until the wider band is left.
   always @(posedge clk_i) begin
      if (rst_i || !enable_i) begin
         on_o <= 1'b0;
      end else if (on_o) begin
         on_o <= keep;
      end else begin
         on_o <= hit_on;
      end
   end
endmodule // arrival_comp
`default_nettype wire

// >>> logic/drive_status_top.v
// Purpose: Pulse counter and assignable status outputs of a drive controller, APB-mapped.
// Assumes: Frequency profile arrives from the internal generator on clk_i; pins are async.
// Notes: Logic outputs are open collector, sink low when the function is active.
// Contract
// [RULE1] Count pulses on count input, up to 100 Hz.
// [RULE2] Count cleared at power-up or drive reset.
// [RULE3] Count-clear input zeroes the cumulative count.
// [RULE4] Count readable only via monitor item.
// [RULE5] Source keeps rate below 250/(response+1) Hz.
// [RULE6] Five logic outputs each assign any function.
// [RULE7] Relay defaults to alarm, accepts any function.
// [RULE8] Run output sinks low while running.
// [RULE9] Run on when frequency exceeds start frequency.
// [RULE10] Type one on at standard set frequency.
// [RULE11] Type two on above threshold one accelerating.
// [RULE12] Type three pulses at threshold one pair.
// [RULE13] Type four on above threshold two accelerating.
// [RULE14] Type five pulses at threshold two pair.
// [RULE15] Arrival turns on 1% max early.
// [RULE16] Arrival turns off after 2% max away.
// [RULE17] Types three, five give separate accel/decel pulses.
// [RULE18] All five arrival functions usable simultaneously.
// [RULE19] Per-terminal selector routes function immediately.
//
// Our own choices: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
`include "drive_status_map.vh"
module drive_status_top #(
   parameter FW = 16,
   parameter CW = 32
) (
   // Clock and reset.
   input wire clk_i,
   input wire rst_i,
   // APB slave.
   input wire psel_i,
   input wire penable_i,
   input wire pwrite_i,
   input wire [11:0] paddr_i,
   input wire [31:0] pwdata_i,
   output reg [31:0] prdata_o,
   output reg pready_o,
   output reg pslverr_o,
   // Frequency profile from the internal generator.
   input wire [FW-1:0] out_freq_i,
   input wire accel_i,
   input wire decel_i,
   input wire alarm_i,
   // Logic input pins.
   input wire count_pulse_input,
   input wire count_clear_input,
   // Open-collector outputs, enable high while sinking to common.
   output reg [4:0] oc_oe_o,
   // Relay coil drive, high energises.
   output reg relay_o,
   // Interrupt.
   output reg irq_o
);
   // Selector extraction used for all six terminals.
   function [2:0] sel_of;
      input [20:0] v;
      input [2:0] idx;
      begin
         sel_of = v[idx*3 +: 3];
      end
   endfunction
   // Function mux used for all six terminals.
   function fsel;
      input [2:0] code;
      input [6:0] fv;
      begin
         fsel = (code == `FUNC_OFF) ? 1'b0 : fv[code];
      end
   endfunction

   // Configuration registers.
   reg ctrl_run_r; // Run mode from the sequencer.
   reg ctrl_clr_r; // Software count clear, self-clearing.
   reg [FW-1:0] start_freq_r; // Start frequency setting.
   reg [FW-1:0] set_freq_r; // Standard set frequency.
   reg [FW-1:0] acc_th1_r; // Accel threshold one.
   reg [FW-1:0] dec_th1_r; // Decel threshold one.
   reg [FW-1:0] acc_th2_r; // Accel threshold two.
   reg [FW-1:0] dec_th2_r; // Decel threshold two.
   reg [FW-1:0] max_freq_r; // Maximum frequency.
   reg [20:0] out_sel_r; // Seven 3-bit selectors, six used.
   reg [CW-1:0] count_r; // Cumulative pulse count.
   reg [`IRQ_W-1:0] irq_stat_r; // Sticky events.
   reg [`IRQ_W-1:0] irq_en_r; // Interrupt enables.

   // Pins move with no regard to clk_i, so stage one may go
   // metastable; it gets a full cycle to settle first.
   // The third count flop only remembers the last level.
   // Two-flop synchronisers for pins; logic reads stage two and the third count flop, never stage one.
   reg pc_s1_r, pc_s2_r, pc_d_r;
   reg cc_s1_r, cc_s2_r;
   always @(posedge clk_i) begin
      if (rst_i) begin
         pc_s1_r <= 1'b0;
         pc_s2_r <= 1'b0;
         pc_d_r <= 1'b0;
         cc_s1_r <= 1'b0;
         cc_s2_r <= 1'b0;
      end else begin
         pc_s1_r <= count_pulse_input;
         pc_s2_r <= pc_s1_r;
         pc_d_r <= pc_s2_r;
         cc_s1_r <= count_clear_input;
         cc_s2_r <= cc_s1_r;
      end
   end
   // Rising edge of the synchronised count input; 100 Hz is far below clk rate.
   wire pulse_rise = pc_s2_r & ~pc_d_r;

   // Band widths: 1% and 2% of maximum frequency.
   // Integer division rounds the bands down; with the reset
   // maximum of all ones they are 655 and 1310 steps.
   wire [FW-1:0] on_band = max_freq_r / 7'd100; // [RULE15]
   wire [FW-1:0] off_band = max_freq_r / 7'd50; // [RULE16]

   // APB decode; every transfer completes in its first access cycle.
   // Only aligned offsets of the map are accepted; any other
   // address answers with an error, reads as zero and ignores
   // a write.
   wire apb_acc = psel_i & penable_i;
   wire apb_wr = apb_acc & pwrite_i;
   reg addr_ok;
   always @* begin
      case (paddr_i)
         `OFS_CTRL, `OFS_START_FREQ, `OFS_SET_FREQ, `OFS_ACC_TH1, `OFS_DEC_TH1,
         `OFS_ACC_TH2, `OFS_DEC_TH2, `OFS_MAX_FREQ, `OFS_OUT_SEL, `OFS_COUNT_MON,
         `OFS_STATUS, `OFS_IRQ_STAT, `OFS_IRQ_EN, `OFS_IRQ_CLR: addr_ok = 1'b1;
         default: addr_ok = 1'b0;
      endcase
   end

   // Configuration writes. Run mode stored here; clear bit pulses for one cycle.
   // A write lands on the edge where psel and penable are both
   // high, the edge at which the master samples ready.
   // Maximum frequency resets to all ones so the bands are
   // never zero before software sets the real value.
   // The selector word holds seven 3-bit fields: terminals 0 to 4,
   // then the relay, then one unused field.
   always @(posedge clk_i) begin
      if (rst_i) begin
         ctrl_run_r <= 1'b0;
         ctrl_clr_r <= 1'b0;
         start_freq_r <= {FW{1'b0}};
         set_freq_r <= {FW{1'b0}};
         acc_th1_r <= {FW{1'b0}};
         dec_th1_r <= {FW{1'b0}};
         acc_th2_r <= {FW{1'b0}};
         dec_th2_r <= {FW{1'b0}};
         max_freq_r <= {FW{1'b1}};
         out_sel_r <= `OUT_SEL_RST; // [RULE7]
         irq_en_r <= {`IRQ_W{1'b0}};
      end else begin
         ctrl_clr_r <= 1'b0;
         if (apb_wr) begin
            case (paddr_i)
               `OFS_CTRL: begin
                  ctrl_run_r <= pwdata_i[`CTRL_RUN_BIT];
                  ctrl_clr_r <= pwdata_i[`CTRL_CLR_BIT];
               end
               `OFS_START_FREQ: start_freq_r <= pwdata_i[FW-1:0];
               `OFS_SET_FREQ: set_freq_r <= pwdata_i[FW-1:0];
               `OFS_ACC_TH1: acc_th1_r <= pwdata_i[FW-1:0];
               `OFS_DEC_TH1: dec_th1_r <= pwdata_i[FW-1:0];
               `OFS_ACC_TH2: acc_th2_r <= pwdata_i[FW-1:0];
               `OFS_DEC_TH2: dec_th2_r <= pwdata_i[FW-1:0];
               `OFS_MAX_FREQ: max_freq_r <= pwdata_i[FW-1:0];
               `OFS_OUT_SEL: out_sel_r <= pwdata_i[20:0]; // [RULE6] [RULE19]
               `OFS_IRQ_EN: irq_en_r <= pwdata_i[`IRQ_W-1:0];
               default: ;
            endcase
         end
      end
   end

   // Pulse counter. Clear has priority over a coincident pulse; the monitor
   // read is the only view of this value, nothing else stores it.
   // The count wraps at full width; at the rated pulse rate that
   // takes longer than any drive stays powered.
   // Clear from the pin holds the count at zero while high.
   always @(posedge clk_i) begin
      if (rst_i) begin
         count_r <= {CW{1'b0}}; // [RULE2]
      end else if (cc_s2_r || ctrl_clr_r) begin
         count_r <= {CW{1'b0}}; // [RULE3]
      end else if (pulse_rise) begin
         count_r <= count_r + {{(CW-1){1'b0}}, 1'b1}; // [RULE1]
      end
   end

   // Run indication: run mode and output above start frequency.
   // A zero start setting still needs some output frequency,
   // since the compare is strict.
   // The flop adds one cycle before the terminal drive sees it.
   reg run_r;
   always @(posedge clk_i) begin
      if (rst_i) begin
         run_r <= 1'b0;
      end else begin
         run_r <= ctrl_run_r && (out_freq_i > start_freq_r); // [RULE9]
      end
   end

   // Arrival comparators; all seven run in parallel.
   // Level types two and four are held off in pure deceleration,
   // so they mark the rising side of the profile only.
   // Window types three and five keep one comparator per phase;
   // a phase flip clears the old copy, so each phase gives its
   // own pulse. Both phase inputs equal counts as neither phase.
   // All seven comparators run at once: one each for types one, two and four, two each for types three and five.
   wire [4:0] fa;
   wire acc_phase = accel_i & ~decel_i;
   wire dec_phase = decel_i & ~accel_i;
   wire [4:0] fa_acc, fa_dec;
   // Type one: window at set frequency.
   arrival_comp #(.W(FW)) u_fa1 (.clk_i(clk_i), .rst_i(rst_i), .freq_i(out_freq_i),
      .thr_i(set_freq_r), .on_band_i(on_band), .off_band_i(off_band),
      .window_i(1'b1), .enable_i(1'b1), .on_o(fa[0])); // [RULE10]
   // Type two: at or above threshold one while accelerating.
   arrival_comp #(.W(FW)) u_fa2 (.clk_i(clk_i), .rst_i(rst_i), .freq_i(out_freq_i),
      .thr_i(acc_th1_r), .on_band_i(on_band), .off_band_i(off_band),
      .window_i(1'b0), .enable_i(~dec_phase), .on_o(fa[1])); // [RULE11]
   // Type three accel and decel windows, disjoint phases.
   arrival_comp #(.W(FW)) u_fa3a (.clk_i(clk_i), .rst_i(rst_i), .freq_i(out_freq_i),
      .thr_i(acc_th1_r), .on_band_i(on_band), .off_band_i(off_band),
      .window_i(1'b1), .enable_i(acc_phase), .on_o(fa_acc[2])); // [RULE12]
   arrival_comp #(.W(FW)) u_fa3d (.clk_i(clk_i), .rst_i(rst_i), .freq_i(out_freq_i),
      .thr_i(dec_th1_r), .on_band_i(on_band), .off_band_i(off_band),
      .window_i(1'b1), .enable_i(dec_phase), .on_o(fa_dec[2])); // [RULE12]
   // Type four: at or above threshold two while accelerating.
   arrival_comp #(.W(FW)) u_fa4 (.clk_i(clk_i), .rst_i(rst_i), .freq_i(out_freq_i),
      .thr_i(acc_th2_r), .on_band_i(on_band), .off_band_i(off_band),
      .window_i(1'b0), .enable_i(~dec_phase), .on_o(fa[3])); // [RULE13]
   // Type five accel and decel windows.
   arrival_comp #(.W(FW)) u_fa5a (.clk_i(clk_i), .rst_i(rst_i), .freq_i(out_freq_i),
      .thr_i(acc_th2_r), .on_band_i(on_band), .off_band_i(off_band),
      .window_i(1'b1), .enable_i(acc_phase), .on_o(fa_acc[4])); // [RULE14]
   arrival_comp #(.W(FW)) u_fa5d (.clk_i(clk_i), .rst_i(rst_i), .freq_i(out_freq_i),
      .thr_i(dec_th2_r), .on_band_i(on_band), .off_band_i(off_band),
      .window_i(1'b1), .enable_i(dec_phase), .on_o(fa_dec[4])); // [RULE14]
   // Window mode ends each pulse once the frequency passes the band.
   assign fa[2] = fa_acc[2] | fa_dec[2]; // [RULE17]
   assign fa[4] = fa_acc[4] | fa_dec[4]; // [RULE17]
   assign fa_acc[0] = 1'b0;
   assign fa_acc[1] = 1'b0;
   assign fa_acc[3] = 1'b0;
   assign fa_dec[0] = 1'b0;
   assign fa_dec[1] = 1'b0;
   assign fa_dec[3] = 1'b0;

   // Function vector indexed by the selector code.
   wire [6:0] func_vec = {alarm_i, fa, run_r}; // [RULE18]

   // Terminal drive: each selector routes its function on the next edge.
   // Code seven leaves a terminal released. A function reaches
   // its pin one edge after a selector write, and two edges
   // after a frequency change, as the comparators are flops too.
   integer k;
   reg [4:0] oc_nxt;
   always @* begin
      oc_nxt = 5'h00;
      for (k = 0; k < 5; k = k + 1) begin
         oc_nxt[k] = fsel(sel_of(out_sel_r, k[2:0]), func_vec); // [RULE6] [RULE19]
      end
   end
   always @(posedge clk_i) begin
      if (rst_i) begin
         oc_oe_o <= 5'h00;
         relay_o <= 1'b0;
      end else begin
         oc_oe_o <= oc_nxt; // [RULE8]
         relay_o <= fsel(sel_of(out_sel_r, 3'd5), func_vec); // [RULE7]
      end
   end

   // Sticky event flags: count pulse, each arrival rise, alarm rise.
   // Bit 0 records count pulses only: the run level shows in the
   // status word, but as a flag it would be set again on every
   // cycle and could never be cleared.
   reg [`IRQ_W-1:0] ev_d_r;
   wire [`IRQ_W-1:0] ev_lvl = {alarm_i, fa, run_r};
   wire [`IRQ_W-1:0] ev_rise = ({ev_lvl[`IRQ_W-1:1], 1'b0} & ~ev_d_r) |
                               {{(`IRQ_W-1){1'b0}}, pulse_rise};
   wire [`IRQ_W-1:0] clr_mask = (apb_wr && paddr_i == `OFS_IRQ_CLR) ?
                                pwdata_i[`IRQ_W-1:0] : {`IRQ_W{1'b0}};
   always @(posedge clk_i) begin
      if (rst_i) begin
         ev_d_r <= {`IRQ_W{1'b0}};
         irq_stat_r <= {`IRQ_W{1'b0}};
         irq_o <= 1'b0;
      end else begin
         ev_d_r <= {ev_lvl[`IRQ_W-1:1], 1'b0};
         // Set wins over a clear in the same cycle.
         irq_stat_r <= (irq_stat_r & ~clr_mask) | ev_rise;
         irq_o <= |(((irq_stat_r & ~clr_mask) | ev_rise) & irq_en_r);
      end
   end

   // APB read data and response, registered; ready in the access cycle's edge.
   // Read data are decoded from the setup-cycle address and
   // registered, so they stand through the access cycle.
   // The count appears here and nowhere else.
   reg [31:0] rd_nxt;
   always @* begin
      rd_nxt = 32'h00000000;
      case (paddr_i)
         `OFS_CTRL: rd_nxt = {31'h00000000, ctrl_run_r};
         `OFS_START_FREQ: rd_nxt[FW-1:0] = start_freq_r;
         `OFS_SET_FREQ: rd_nxt[FW-1:0] = set_freq_r;
         `OFS_ACC_TH1: rd_nxt[FW-1:0] = acc_th1_r;
         `OFS_DEC_TH1: rd_nxt[FW-1:0] = dec_th1_r;
         `OFS_ACC_TH2: rd_nxt[FW-1:0] = acc_th2_r;
         `OFS_DEC_TH2: rd_nxt[FW-1:0] = dec_th2_r;
         `OFS_MAX_FREQ: rd_nxt[FW-1:0] = max_freq_r;
         `OFS_OUT_SEL: rd_nxt[20:0] = out_sel_r;
         `OFS_COUNT_MON: rd_nxt[CW-1:0] = count_r; // [RULE4]
         `OFS_STATUS: rd_nxt[`IRQ_W-1:0] = ev_lvl;
         `OFS_IRQ_STAT: rd_nxt[`IRQ_W-1:0] = irq_stat_r;
         `OFS_IRQ_EN: rd_nxt[`IRQ_W-1:0] = irq_en_r;
         default: rd_nxt = 32'h00000000;
      endcase
   end
   // Ready is raised at the start of access, registered in the setup cycle, so read data is a flop output.
   // No wait states: every transfer ends in its first access
   // cycle, which keeps the master's wait short.
   // A refused transfer still ends with ready, with the error flag.
   always @(posedge clk_i) begin
      if (rst_i) begin
         pready_o <= 1'b0;
         pslverr_o <= 1'b0;
         prdata_o <= 32'h00000000;
      end else begin
         pready_o <= psel_i & ~penable_i;
         pslverr_o <= psel_i & ~penable_i & ~addr_ok;
         prdata_o <= rd_nxt;
      end
   end
endmodule // drive_status_top
`default_nettype wire

// >>> test/drive_status_checker.sv
// Purpose: Port-level checks of the drive status block.
// Assumes: One clock and a synchronous, active-high reset.
// Notes: A local copy of the selectors follows bus writes, so routing is judged without reads.
`timescale 1ns/1ps
`default_nettype none
`include "drive_status_map.vh"
module drive_status_checker #(
   parameter FW = 16
) (
   // Clock, reset and bus.
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [11:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   input wire logic [31:0] prdata_o,
   input wire logic pready_o,
   input wire logic pslverr_o,
   // Profile, pins and outputs.
   input wire logic [FW-1:0] out_freq_i,
   input wire logic alarm_i,
   input wire logic count_clear_input,
   input wire logic [4:0] oc_oe_o,
   input wire logic relay_o,
   input wire logic irq_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   // A completed transfer, and a completed read of the count.
   logic acc;
   logic rd_cnt;
   logic [20:0] sel_q;
   assign acc = psel_i && penable_i && pready_o;
   assign rd_cnt = acc && !pwrite_i && paddr_i == `OFS_COUNT_MON;
   // Selector copy; it changes on the edge where the write takes effect.
   always @(posedge clk_i) begin
      if (rst_i) begin
         sel_q <= `OUT_SEL_RST;
      end else if (acc && pwrite_i && paddr_i == `OFS_OUT_SEL) begin
         sel_q <= pwdata_i[20:0];
      end
   end
   apb_answer_a: assert property (psel_i && !penable_i |=> pready_o)
      else $error("ready missing in access cycle");
   ready_pulse_a: assert property (pready_o |=> !pready_o)
      else $error("ready held too long");
   unmapped_err_a: assert property (acc && paddr_i > `OFS_IRQ_CLR |->
      pslverr_o && (pwrite_i || prdata_o == 32'h00000000))
      else $error("unmapped access not refused");
   clear_zero_a: assert property (count_clear_input [*6] ##0 rd_cnt |->
      prdata_o == 32'h00000000)
      else $error("count not zero under clear");
   reset_quiet_a: assert property ($fell(rst_i) |-> oc_oe_o == 5'h00 && !irq_o)
      else $error("outputs active after reset");
   all_off_a: assert property (acc && pwrite_i && paddr_i == `OFS_OUT_SEL &&
      pwdata_i[20:0] == 21'h1FFFFF |-> ##3 (oc_oe_o == 5'h00 && !relay_o))
      else $error("off selector still drives");
   irq_mask_a: assert property (acc && pwrite_i && paddr_i == `OFS_IRQ_EN &&
      pwdata_i[6:0] == 7'h00 |-> ##3 !irq_o)
      else $error("masked interrupt still high");
   run_idle_a: assert property ((sel_q[17:15] == `FUNC_RUN && out_freq_i == '0) [*4]
      |-> !relay_o)
      else $error("run shown at zero frequency");
   alarm_route_a: assert property ((sel_q[17:15] == `FUNC_ALARM && $stable(alarm_i)) [*3]
      |-> relay_o == alarm_i)
      else $error("relay does not follow alarm");
   cover property (count_clear_input [*6] ##0 rd_cnt);
   cover property (acc && pslverr_o);
   cover property ($rose(relay_o));
endmodule // drive_status_checker
bind drive_status_top drive_status_checker #(.FW(FW)) chk (
   .clk_i(clk_i), .rst_i(rst_i), .psel_i(psel_i), .penable_i(penable_i),
   .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
   .pready_o(pready_o), .pslverr_o(pslverr_o), .out_freq_i(out_freq_i),
   .alarm_i(alarm_i), .count_clear_input(count_clear_input), .oc_oe_o(oc_oe_o),
   .relay_o(relay_o), .irq_o(irq_o));
`default_nettype wire

// >>> test/pulse_source.sv
// Purpose: External controller driving the count and count-clear terminals.
// Assumes: A one-cycle go starts a frame of n rising edges.
// Notes: Spacing is scaled far below the field rate so runs stay short.
`timescale 1ns/1ps
`default_nettype none
module pulse_source #(
   parameter HALF = 6
) (
   // Clock.
   input wire logic clk_i,
   // Requests from the bench.
   input wire logic go_i,
   input wire logic [3:0] n_i,
   input wire logic clr_req_i,
   // Terminals and status.
   output var logic pulse_o,
   output var logic clr_o,
   output logic busy_o
);
   // Half periods left in the frame, and cycles within the current half.
   logic [4:0] left_r = 5'h00;
   logic [3:0] ph_r = 4'h0;
   initial pulse_o = 1'h0;
   initial clr_o = 1'h0;
   // Equal high and low halves keep a 50% duty; the line rests low between frames.
   always @(posedge clk_i) begin
      clr_o <= clr_req_i;
      if (go_i && left_r == 5'h00) begin
         left_r <= {n_i, 1'h0};
         ph_r <= 4'h0;
      end else if (left_r != 5'h00) begin
         if (ph_r == HALF - 1) begin
            ph_r <= 4'h0;
            pulse_o <= ~pulse_o;
            left_r <= left_r - 5'h01;
         end else begin
            ph_r <= ph_r + 4'h1;
         end
      end
   end
   assign busy_o = (left_r != 5'h00);
endmodule // pulse_source
`default_nettype wire

// >>> test/drive_pulse_count_status_outputs_bench.sv
// Purpose: Self-checking bench for the pulse counter and assignable status outputs.
// Assumes: Max frequency set to 10000, so the bands are 100 on and 200 off.
// Notes: Expectations come from the table and functions below, never from the design.
`timescale 1ns/1ps
`default_nettype none
`include "drive_status_map.vh"
module drive_pulse_count_status_outputs_bench;
   logic clk_i, rst_i, psel, penable, pwrite, accel, decel, alarm, go, clr_req;
   logic pulse, clr, busy, pready, pslverr, relay, irq, er;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [15:0] freq;
   logic [4:0] oc;
   logic [3:0] n, k;
   logic [17:0] sel;
   int n_fail, checks_done, sd;
   // Profile steps and the expected {relay, terminals 4..0} after each.
   logic [15:0] fq[12] = '{16'h0000, 16'h0258, 16'h076D, 16'h0866, 16'h08CA, 16'h0B86,
      16'h0F78, 16'h0DDE, 16'h0CB2, 16'h062C, 16'h04B0, 16'h0000};
   logic [5:0] ex[12] = '{6'h00, 6'h20, 6'h26, 6'h26, 6'h22, 6'h23, 6'h3A, 6'h30, 6'h20,
      6'h24, 6'h20, 6'h00};
   // Terminals carry arrival types one to five, relay carries run.
   localparam logic [17:0] TSEL = {`FUNC_RUN, `FUNC_FA5, `FUNC_FA4, `FUNC_FA3, `FUNC_FA2,
      `FUNC_FA1};
   drive_status_top uut (.clk_i(clk_i), .rst_i(rst_i), .psel_i(psel), .penable_i(penable),
      .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
      .pready_o(pready), .pslverr_o(pslverr), .out_freq_i(freq), .accel_i(accel),
      .decel_i(decel), .alarm_i(alarm), .count_pulse_input(pulse),
      .count_clear_input(clr), .oc_oe_o(oc), .relay_o(relay), .irq_o(irq));
   pulse_source src (.clk_i(clk_i), .go_i(go), .n_i(n), .clr_req_i(clr_req),
      .pulse_o(pulse), .clr_o(clr), .busy_o(busy));
   initial begin
      clk_i = 1'h0;
      forever #10 clk_i = ~clk_i;
   end
   // State of each function code at the 3960 accelerating step.
   function automatic logic fval(input logic [2:0] c, input logic a);
      logic [7:0] st;
      st = {1'h0, a, 6'h35};
      return st[c];
   endfunction
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         n_fail++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   // One APB transfer; held until ready is sampled high, bounded by a cycle limit.
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int i;
      @(posedge clk_i);
      psel <= 1'h1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_i);
      penable <= 1'h1;
      i = 0;
      do begin
         @(posedge clk_i);
         i++;
      end while (pready !== 1'h1 && i < 50);
      if (i >= 50) n_fail++;
      rd = prdata;
      er = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
   endtask
   task automatic burst(input logic [3:0] c);
      @(posedge clk_i);
      go <= 1'h1;
      n <= c;
      @(posedge clk_i);
      go <= 1'h0;
      @(posedge clk_i);
      for (int i = 0; i < 400 && busy; i++) @(posedge clk_i);
      repeat (5) @(posedge clk_i);
   endtask
   task automatic conclude;
      $display("checks %0d mismatches %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   initial begin
      repeat (60000) @(posedge clk_i);
      n_fail++;
      conclude;
   end
   initial begin
      {psel, penable, pwrite, accel, decel, alarm, go, clr_req} = 8'h00;
      paddr = 12'h000;
      pwdata = 32'h00000000;
      freq = 16'h0000;
      n = 4'h0;
      rst_i = 1'h1;
      sd = $urandom(12);
      repeat (3) @(posedge clk_i);
      rst_i <= 1'h0;
      apb(0, `OFS_OUT_SEL, 0);
      chk({rd[17:15], rd[5:0]}, {`FUNC_ALARM, `FUNC_RUN, `FUNC_FA1});
      apb(0, `OFS_COUNT_MON, 0);
      chk(rd, 0);
      chk(oc, 5'h01);
      apb(1, `OFS_IRQ_EN, 32'h00000001);
      k = 4'($urandom_range(15, 1));
      burst(k);
      apb(1, `OFS_COUNT_MON, 32'h0000FFFF);
      apb(0, `OFS_COUNT_MON, 0);
      chk(rd, k);
      chk(irq, 1);
      apb(1, `OFS_IRQ_EN, 0);
      repeat (3) @(posedge clk_i);
      chk(irq, 0);
      apb(1, `OFS_IRQ_EN, 32'h00000001);
      repeat (3) @(posedge clk_i);
      chk(irq, 1);
      apb(1, `OFS_IRQ_CLR, 32'h00000001);
      repeat (3) @(posedge clk_i);
      apb(0, `OFS_IRQ_STAT, 0);
      chk({rd[`IRQ_CNT_BIT], irq}, 0);
      clr_req <= 1'h1;
      repeat (8) @(posedge clk_i);
      apb(0, `OFS_COUNT_MON, 0);
      chk(rd, 0);
      clr_req <= 1'h0;
      burst(4'h3);
      apb(1, `OFS_CTRL, 32'h00000002);
      apb(0, `OFS_COUNT_MON, 0);
      chk(rd, 0);
      burst(4'hF);
      rst_i <= 1'h1;
      repeat (3) @(posedge clk_i);
      rst_i <= 1'h0;
      apb(0, `OFS_COUNT_MON, 0);
      chk(rd, 0);
      apb(0, 12'h100, 0);
      chk({er, rd}, {1'h1, 32'h00000000});
      apb(1, `OFS_START_FREQ, 32'h000001F4);
      apb(1, `OFS_SET_FREQ, 32'h00000BB8);
      apb(1, `OFS_ACC_TH1, 32'h000007D0);
      apb(1, `OFS_DEC_TH1, 32'h000005DC);
      apb(1, `OFS_ACC_TH2, 32'h00000FA0);
      apb(1, `OFS_DEC_TH2, 32'h00000DAC);
      apb(1, `OFS_MAX_FREQ, 32'h00002710);
      apb(1, `OFS_CTRL, 32'h00000001);
      apb(1, `OFS_OUT_SEL, {14'h0000, TSEL});
      for (int i = 0; i < 12; i++) begin
         @(posedge clk_i);
         freq <= fq[i];
         accel <= (i < 7);
         decel <= (i >= 7);
         repeat (3) @(posedge clk_i);
         chk({relay, oc}, ex[i]);
         if (i == 6) begin
            repeat (8) begin
               sel = 18'($urandom);
               alarm <= 1'($urandom);
               apb(1, `OFS_OUT_SEL, {14'h0000, sel});
               repeat (3) @(posedge clk_i);
               for (int t = 0; t < 5; t++) chk(oc[t], fval(sel[3*t+:3], alarm));
               chk(relay, fval(sel[17:15], alarm));
            end
            apb(1, `OFS_OUT_SEL, {14'h0000, TSEL});
         end
      end
      apb(1, `OFS_OUT_SEL, 32'h001FFFFF);
      repeat (3) @(posedge clk_i);
      chk({relay, oc}, 0);
      conclude;
   end
endmodule // drive_pulse_count_status_outputs_bench
`default_nettype wire
